// File: hdl/bcu_params.svh
`ifndef BCU_PARAMS_SVH
`define BCU_PARAMS_SVH

// ==========================================================================
// Widths
// ==========================================================================
`define BCU_PC_W        22
`define BCU_PTR_W       16
`define BCU_K_W         12
`define BCU_DATA_W      8

// ==========================================================================
// Status register bit positions
// ==========================================================================
`define BCU_SF_C        0
`define BCU_SF_Z        1
`define BCU_SF_N        2
`define BCU_SF_V        3
`define BCU_SF_S        4
`define BCU_SF_I        7

// ==========================================================================
// Program counter steps and reset values
// ==========================================================================
`define BCU_REL_INC     2'h1
`define BCU_SEQ_INC     2'h1
`define BCU_SKIP_SHORT  2'h2
`define BCU_SKIP_LONG   2'h3
`define BCU_STATUS_RST  8'h00

`endif

// File: hdl/bcu_pkg.sv
// ==========================================================================
// Shared types of the branch and compare unit
// ==========================================================================
package bcu_pkg;

	// Decoded control-flow and compare operations.
	typedef enum logic [4:0] {
		bcu_op_idle,
		bcu_op_relative_jump,
		bcu_op_indirect_jump,
		bcu_op_relative_call,
		bcu_op_indirect_call,
		bcu_op_subroutine_return,
		bcu_op_interrupt_return,
		bcu_op_compare_skip_equal,
		bcu_op_register_compare,
		bcu_op_compare_with_carry,
		bcu_op_compare_immediate,
		bcu_op_skip_reg_bit_clear,
		bcu_op_skip_reg_bit_set,
		bcu_op_skip_io_bit_clear,
		bcu_op_skip_io_bit_set,
		bcu_op_branch_flag_set,
		bcu_op_branch_flag_clear,
		bcu_op_branch_carry_set,
		bcu_op_branch_carry_clear
	} bcu_op_e;

endpackage

// File: hdl/bcu_pc_adder.sv
`timescale 1ns/1ps
`include "bcu_params.svh"

// ==========================================================================
// Program counter adder: base plus signed offset plus a small step
// ==========================================================================
module bcu_pc_adder #(
	parameter int PC_W = `BCU_PC_W,
	parameter int K_W  = `BCU_K_W
) (
	input  wire logic [PC_W-1:0] base,   // Address the step starts from.
	input  wire logic [K_W-1:0]  ofs,    // Signed word offset.
	input  wire logic [1:0]      inc,    // Unsigned extra step.
	output logic      [PC_W-1:0] sum     // Wrapped target address.
);

	// The offset must be narrower than the counter to be sign extended.
	if (K_W >= PC_W || PC_W < 3) begin : g_chk
		$error("bcu_pc_adder: offset wider than program counter");
	end

	logic [PC_W-1:0] ofs_ext;
	logic [PC_W-1:0] inc_ext;

	// Sign extension keeps backward branches wrapping inside the space.
	assign ofs_ext = {{(PC_W-K_W){ofs[K_W-1]}}, ofs};
	assign inc_ext = {{(PC_W-2){1'b0}}, inc};
	assign sum     = base + ofs_ext + inc_ext;

endmodule // bcu_pc_adder

// File: hdl/bcu_sub_flags.sv
`timescale 1ns/1ps
`include "bcu_params.svh"

// ==========================================================================
// Subtractor that yields the compare flags and discards the difference
// ==========================================================================
module bcu_sub_flags #(
	parameter int W = `BCU_DATA_W
) (
	input  wire logic [W-1:0] a,        // Minuend.
	input  wire logic [W-1:0] b,        // Subtrahend.
	input  wire logic         cin,      // Borrow in.
	output logic              zero,     // Difference is zero.
	output logic              carry,    // Borrow out.
	output logic              neg,      // Difference sign bit.
	output logic              ovf,      // Signed overflow.
	output logic              sign      // Negative xor overflow.
);

	if (W < 2) begin : g_chk
		$error("bcu_sub_flags: width below two bits");
	end

	logic [W:0]   wide;
	logic [W-1:0] diff;

	// One extra bit holds the borrow, so no flag needs a second adder.
	assign wide  = {1'b0, a} - {1'b0, b} - {{W{1'b0}}, cin};
	assign diff  = wide[W-1:0];
	assign carry = wide[W];
	assign zero  = (diff == '0);
	assign neg   = diff[W-1];
	assign ovf   = (a[W-1] & ~b[W-1] & ~diff[W-1]) |
		(~a[W-1] & b[W-1] & diff[W-1]);
	assign sign  = neg ^ ovf;

endmodule // bcu_sub_flags

// File: hdl/bcu_branch_compare.sv
// Function
// (RULE1) Relative jump and call add k plus one.
// (RULE2) Indirect forms: low sixteen from pointer, rest zero.
// (RULE3) Subroutine return reloads counter from stack.
// (RULE4) Interrupt return reloads counter, sets interrupt enable.
// (RULE5) Equal registers skip next instruction, two or three.
// (RULE6) Register compare sets flags from destination minus source.
// (RULE7) Compare with carry also subtracts carry.
// (RULE8) Immediate compare subtracts the constant.
// (RULE9) Skip when register bit is clear.
// (RULE10) Skip when register bit is set.
// (RULE11) Skip when I/O bit is clear.
// (RULE12) Skip when I/O bit is set.
// (RULE13) Branch when selected status bit is set.
// (RULE14) Branch when selected status bit is clear.
// (RULE15) Branch when carry is set.
// (RULE16) Branch when carry is clear.
// (RULE17) Calls push the following instruction's address.
`timescale 1ns/1ps
`include "bcu_params.svh"

// ==========================================================================
// Branch and compare unit
// ==========================================================================
module bcu_branch_compare
	import bcu_pkg::*;
#(
	parameter int PC_W  = `BCU_PC_W,
	parameter int PTR_W = `BCU_PTR_W,
	parameter int K_W   = `BCU_K_W
) (
	input  wire logic              clk,           // Core clock.
	input  wire logic              srst,          // Synchronous reset.
	input  wire logic              op_valid,      // Operation present.
	input  wire bcu_op_e           op_code,       // Decoded operation.
	input  wire logic [K_W-1:0]    op_k,          // Signed offset k.
	input  wire logic [2:0]        op_bit,        // Bit or flag select.
	input  wire logic [7:0]        reg_d,         // Destination register.
	input  wire logic [7:0]        reg_r,         // Source register.
	input  wire logic [7:0]        op_imm,        // Immediate constant.
	input  wire logic [7:0]        io_byte,       // Byte read at I/O A.
	input  wire logic [PC_W-1:0]   pc,            // Current address.
	input  wire logic [PTR_W-1:0]  pointer,       // Pointer pair value.
	input  wire logic [PC_W-1:0]   stack_pc,      // Address on stack top.
	input  wire logic [7:0]        status_in,     // Current status.
	input  wire logic              next_two_word, // Next is two words.
	output logic                   res_valid,     // Result present.
	output logic [PC_W-1:0]        pc_next,       // New program counter.
	output logic [7:0]             status_out,    // New status value.
	output logic                   status_we,     // Status write strobe.
	output logic                   push_valid,    // Push return address.
	output logic [PC_W-1:0]        push_addr,     // Return address.
	output logic                   pop_valid      // Stack top consumed.
);

	// Sources must be narrower than the counter to be extended into it.
	if (PTR_W >= PC_W || K_W >= PC_W) begin : g_chk
		$error("bcu_branch_compare: counter narrower than its sources");
	end

	// ======================================================================
	// State
	// ======================================================================
	typedef struct packed {
		logic            valid;
		logic [PC_W-1:0] pc;
		logic [7:0]      status;
		logic            status_we;
		logic            push;
		logic [PC_W-1:0] push_addr;
		logic            pop;
	} bcu_state_s;

	bcu_state_s      st;
	bcu_state_s      next_st;
	logic [PC_W-1:0] rel_pc;
	logic [PC_W-1:0] seq_pc;
	logic [PC_W-1:0] skip_pc;
	logic [PC_W-1:0] ind_pc;
	logic [1:0]      skip_inc;
	logic [7:0]      cmp_b;
	logic            cmp_cin;
	logic            f_z, f_c, f_n, f_v, f_s;
	logic            reg_bit, io_bit, flag_bit;
	logic            carry_in;

	// ======================================================================
	// Address arithmetic
	// ======================================================================
	// Separate adders trade area for a short path into the counter mux.
	assign skip_inc = next_two_word ? `BCU_SKIP_LONG : `BCU_SKIP_SHORT; // RULE5
	assign ind_pc   = {{(PC_W-PTR_W){1'b0}}, pointer}; // RULE2

	bcu_pc_adder #(.PC_W(PC_W), .K_W(K_W)) u_rel (
		.base (pc),
		.ofs  (op_k),
		.inc  (`BCU_REL_INC),
		.sum  (rel_pc)
	); // RULE1

	bcu_pc_adder #(.PC_W(PC_W), .K_W(K_W)) u_seq (
		.base (pc),
		.ofs  ('0),
		.inc  (`BCU_SEQ_INC),
		.sum  (seq_pc)
	);
	bcu_pc_adder #(.PC_W(PC_W), .K_W(K_W)) u_skip (
		.base (pc),
		.ofs  ('0),
		.inc  (skip_inc),
		.sum  (skip_pc)
	);

	// ======================================================================
	// Compare datapath
	// ======================================================================
	// The operand and borrow muxes let one subtractor serve the three flag-setting compares.
	assign cmp_b   = (op_code == bcu_op_compare_immediate) ? op_imm : reg_r;
	assign cmp_cin = (op_code == bcu_op_compare_with_carry) &
		status_in[`BCU_SF_C]; // RULE7

	bcu_sub_flags #(.W(8)) u_cmp (
		.a     (reg_d),
		.b     (cmp_b),
		.cin   (cmp_cin),
		.zero  (f_z),
		.carry (f_c),
		.neg   (f_n),
		.ovf   (f_v),
		.sign  (f_s)
	);

	// Selected bits for the skip and branch tests.
	assign reg_bit  = reg_r[op_bit];
	assign io_bit   = io_byte[op_bit];
	assign flag_bit = status_in[op_bit];
	assign carry_in = status_in[`BCU_SF_C];

	// ======================================================================
	// Next state
	// ======================================================================
	// Every operation resolves in one cycle; status_out follows status_in each cycle and takes new bits only with the strobe.
	always_comb begin
		next_st        = '0;
		next_st.status = status_in;
		if (op_valid) begin
			next_st.valid = 1'b1;
			next_st.pc    = seq_pc;
			unique case (op_code)
				bcu_op_relative_jump: next_st.pc = rel_pc; // RULE1
				bcu_op_relative_call: begin
					next_st.pc        = rel_pc; // RULE1
					next_st.push      = 1'b1; // RULE17
					next_st.push_addr = seq_pc; // RULE17
				end
				bcu_op_indirect_jump: next_st.pc = ind_pc; // RULE2
				bcu_op_indirect_call: begin
					next_st.pc        = ind_pc; // RULE2
					next_st.push      = 1'b1; // RULE17
					next_st.push_addr = seq_pc; // RULE17
				end
				bcu_op_subroutine_return: begin
					next_st.pc  = stack_pc; // RULE3
					next_st.pop = 1'b1; // RULE3
				end
				bcu_op_interrupt_return: begin
					next_st.pc                = stack_pc; // RULE4
					next_st.pop               = 1'b1; // RULE4
					next_st.status[`BCU_SF_I] = 1'b1; // RULE4
					next_st.status_we         = 1'b1; // RULE4
				end
				bcu_op_compare_skip_equal: if (reg_d == reg_r)
					next_st.pc = skip_pc; // RULE5
				bcu_op_register_compare,
				bcu_op_compare_with_carry,
				bcu_op_compare_immediate: begin
					next_st.status[`BCU_SF_Z] = f_z; // RULE6 RULE7 RULE8
					next_st.status[`BCU_SF_C] = f_c; // RULE6 RULE7 RULE8
					next_st.status[`BCU_SF_N] = f_n; // RULE6 RULE7 RULE8
					next_st.status[`BCU_SF_V] = f_v; // RULE6 RULE7 RULE8
					next_st.status[`BCU_SF_S] = f_s; // RULE6 RULE7 RULE8
					next_st.status_we         = 1'b1;
				end
				bcu_op_skip_reg_bit_clear: if (!reg_bit)
					next_st.pc = skip_pc; // RULE9
				bcu_op_skip_reg_bit_set: if (reg_bit)
					next_st.pc = skip_pc; // RULE10
				bcu_op_skip_io_bit_clear: if (!io_bit)
					next_st.pc = skip_pc; // RULE11
				bcu_op_skip_io_bit_set: if (io_bit)
					next_st.pc = skip_pc; // RULE12
				bcu_op_branch_flag_set: if (flag_bit)
					next_st.pc = rel_pc; // RULE13
				bcu_op_branch_flag_clear: if (!flag_bit)
					next_st.pc = rel_pc; // RULE14
				bcu_op_branch_carry_set: if (carry_in)
					next_st.pc = rel_pc; // RULE15
				bcu_op_branch_carry_clear: if (!carry_in)
					next_st.pc = rel_pc; // RULE16
				// Idle and illegal codes step on like a plain instruction.
				default: next_st.pc = seq_pc;
			endcase
		end
	end

	// Registered results keep the counter mux off the fetch path.
	always_ff @(posedge clk) begin
		if (srst) begin
			st        <= '0;
			st.status <= `BCU_STATUS_RST;
		end else begin
			st <= next_st;
		end
	end

	// ======================================================================
	// Outputs
	// ======================================================================
	assign res_valid  = st.valid;
	assign pc_next    = st.pc;
	assign status_out = st.status;
	assign status_we  = st.status_we;
	assign push_valid = st.push;
	assign push_addr  = st.push_addr;
	assign pop_valid  = st.pop;

	// ======================================================================
	// Assertions
	// ======================================================================
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic [PC_W-1:0] k_ext;
	assign k_ext = {{(PC_W-K_W){op_k[K_W-1]}}, op_k};

	property p_rel_jump;
		op_valid && op_code == bcu_op_relative_jump |=> res_valid &&
			pc_next == PC_W'($past(pc) + $past(k_ext) + 1) && !status_we;
	endproperty
	a_rel_jump: assert property (p_rel_jump) // RULE1
		else $error("relative jump target wrong");
	property p_ind_call;
		op_valid && op_code == bcu_op_indirect_call |=>
			pc_next[PTR_W-1:0] == $past(pointer) &&
			pc_next[PC_W-1:PTR_W] == '0 && !status_we;
	endproperty
	a_ind_call: assert property (p_ind_call) // RULE2
		else $error("indirect call target wrong");
	property p_sub_return;
		op_valid && op_code == bcu_op_subroutine_return |=>
			pc_next == $past(stack_pc) && pop_valid && !status_we;
	endproperty
	a_sub_return: assert property (p_sub_return) // RULE3
		else $error("return did not reload from stack");
	property p_int_return;
		op_valid && op_code == bcu_op_interrupt_return |=>
			status_we && status_out[`BCU_SF_I] &&
			pc_next == $past(stack_pc);
	endproperty
	a_int_return: assert property (p_int_return) // RULE4
		else $error("interrupt return did not enable interrupts");
	property p_skip_equal_long;
		op_valid && op_code == bcu_op_compare_skip_equal &&
			reg_d == reg_r && next_two_word |=>
			pc_next == PC_W'($past(pc) + 3);
	endproperty
	a_skip_equal_long: assert property (p_skip_equal_long) // RULE5
		else $error("equal compare did not skip two words");
	property p_reg_cmp;
		op_valid && op_code == bcu_op_register_compare |=> status_we &&
			status_out[`BCU_SF_Z] == ($past(reg_d) == $past(reg_r)) &&
			status_out[`BCU_SF_C] == ($past(reg_d) < $past(reg_r));
	endproperty
	a_reg_cmp: assert property (p_reg_cmp) // RULE6
		else $error("register compare flags wrong");
	property p_carry_cmp_borrow;
		op_valid && op_code == bcu_op_compare_with_carry &&
			reg_d == reg_r && status_in[`BCU_SF_C] |=>
			status_out[`BCU_SF_C] && !status_out[`BCU_SF_Z];
	endproperty
	a_carry_cmp_borrow: assert property (p_carry_cmp_borrow) // RULE7
		else $error("compare with carry ignored carry");
	property p_imm_cmp;
		op_valid && op_code == bcu_op_compare_immediate |=>
			status_out[`BCU_SF_Z] == ($past(reg_d) == $past(op_imm));
	endproperty
	a_imm_cmp: assert property (p_imm_cmp) // RULE8
		else $error("immediate compare zero flag wrong");
	property p_reg_clear_skip;
		op_valid && op_code == bcu_op_skip_reg_bit_clear &&
			!reg_r[op_bit] && !next_two_word |=>
			pc_next == PC_W'($past(pc) + 2);
	endproperty
	a_reg_clear_skip: assert property (p_reg_clear_skip) // RULE9
		else $error("clear register bit did not skip");
	property p_io_set_fall;
		op_valid && op_code == bcu_op_skip_io_bit_set &&
			!io_byte[op_bit] |=> pc_next == PC_W'($past(pc) + 1) &&
			!status_we;
	endproperty
	a_io_set_fall: assert property (p_io_set_fall) // RULE12
		else $error("clear I/O bit skipped anyway");
	property p_flag_clear_branch;
		op_valid && op_code == bcu_op_branch_flag_clear &&
			!status_in[op_bit] |=>
			pc_next == PC_W'($past(pc) + $past(k_ext) + 1);
	endproperty
	a_flag_clear_branch: assert property (p_flag_clear_branch) // RULE14
		else $error("branch on clear flag not taken");
	property p_carry_clear_fall;
		op_valid && op_code == bcu_op_branch_carry_clear &&
			status_in[`BCU_SF_C] |=> pc_next == PC_W'($past(pc) + 1);
	endproperty
	a_carry_clear_fall: assert property (p_carry_clear_fall) // RULE16
		else $error("branch on clear carry taken with carry set");
	property p_call_push;
		op_valid && op_code == bcu_op_relative_call |=> push_valid &&
			push_addr == PC_W'($past(pc) + 1) && !status_we;
	endproperty
	a_call_push: assert property (p_call_push) // RULE17
		else $error("call did not push return address");
	property p_idle;
		!op_valid |=> !res_valid && !status_we && !push_valid;
	endproperty
	a_idle: assert property (p_idle)
		else $error("result without operation");

	c_call_return: cover property (op_valid &&
		op_code == bcu_op_relative_call ##[1:8] op_valid &&
		op_code == bcu_op_subroutine_return);
	c_int_return: cover property (op_valid &&
		op_code == bcu_op_interrupt_return);
	c_skip_long: cover property (op_valid && next_two_word &&
		op_code == bcu_op_skip_reg_bit_set && reg_r[op_bit]);
	c_cmp_branch: cover property (op_valid &&
		op_code == bcu_op_register_compare ##1 op_valid &&
		op_code == bcu_op_branch_carry_set);

endmodule // bcu_branch_compare

// File: test/tb_bcu_branch_compare.sv
`timescale 1ns/1ps
`include "bcu_params.svh"

// ==========================================================================
// Self-checking bench of the branch and compare unit
// ==========================================================================
module tb_bcu_branch_compare
	import bcu_pkg::*;
;
	// Expected outcome of one accepted operation; grp names the group, and every group gets the same pc check.
	typedef struct packed {
		logic [1:0]  grp;
		logic [21:0] pc;
		logic [7:0]  st;
		logic        swe;
		logic        push;
		logic [21:0] pa;
		logic        pop;
	} bcu_note_s;

	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        op_valid = 1'b0;
	bcu_op_e     op_code = bcu_op_idle;
	logic [11:0] op_k = 12'h000;
	logic [2:0]  op_bit = 3'h0;
	logic [7:0]  reg_d = 8'h00;
	logic [7:0]  reg_r = 8'h00;
	logic [7:0]  op_imm = 8'h00;
	logic [7:0]  io_byte = 8'h00;
	logic [21:0] pc = 22'h000000;
	logic [15:0] pointer = 16'h0000;
	logic [21:0] stack_pc = 22'h000000;
	logic [7:0]  status_in = 8'h00;
	logic        next_two_word = 1'b0;
	logic        res_valid;
	logic [21:0] pc_next;
	logic [7:0]  status_out;
	logic        status_we;
	logic        push_valid;
	logic [21:0] push_addr;
	logic        pop_valid;
	logic [31:0] seed = 32'h4af9aa47;
	bcu_note_s   notes[$];
	int          mismatches = 0;
	int          checks = 0;
	int          cycles = 0;

	bcu_branch_compare uut (
		.clk(clk), .srst(srst), .op_valid(op_valid), .op_code(op_code),
		.op_k(op_k), .op_bit(op_bit), .reg_d(reg_d), .reg_r(reg_r),
		.op_imm(op_imm), .io_byte(io_byte), .pc(pc), .pointer(pointer),
		.stack_pc(stack_pc), .status_in(status_in),
		.next_two_word(next_two_word), .res_valid(res_valid),
		.pc_next(pc_next), .status_out(status_out), .status_we(status_we),
		.push_valid(push_valid), .push_addr(push_addr),
		.pop_valid(pop_valid)
	);

	// ======================================================================
	// Clock and hang guard
	// ======================================================================
	// A 40 MHz core clock.
	always #12.5 clk = ~clk;

	// The whole run needs about 1300 cycles; 4000 means something hung.
	always @(posedge clk) begin
		cycles++;
		if (cycles >= 4000) begin
			mismatches++;
			report_and_stop();
		end
	end

	// ======================================================================
	// Helpers
	// ======================================================================
	// Xorshift source so every run sees the same stimulus.
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Status after a discarded subtraction a - b - ci; H, T and I are kept.
	function automatic logic [7:0] fl(input logic [7:0] st, a, b,
			input logic ci);
		logic [8:0] d;
		logic       v;
		d = {1'b0, a} - {1'b0, b} - {8'h00, ci};
		v = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
		return {st[7:5], d[7] ^ v, v, d[7], d[7:0] == 8'h00, d[8]};
	endfunction

	// Common mismatch report and count.
	task automatic miss(input logic [21:0] g, x);
		mismatches++;
		$display("unexpected at %0t: got %h expected %h", $time, g, x);
	endtask

	// Compare of an address result.
	task automatic cmp_pc(input logic [21:0] g, x);
		checks++;
		if (g !== x) miss(g, x);
	endtask

	// Compare of a status byte.
	task automatic cmp_st(input logic [7:0] g, x);
		checks++;
		if (g !== x) miss({14'h0000, g}, {14'h0000, x});
	endtask

	// Compare of a strobe.
	task automatic cmp_bit(input logic g, x);
		checks++;
		if (g !== x) miss({21'h000000, g}, {21'h000000, x});
	endtask

	// ======================================================================
	// Driver: random operands at the falling edge, expectation noted
	// ======================================================================
	task automatic drive(input bcu_op_e op);
		bcu_note_s   e;
		logic [31:0] r1, r2, r3, r4;
		logic [21:0] seq, rel, skp;
		r1 = xs();
		r2 = xs();
		r3 = xs();
		r4 = xs();
		op_valid = 1'b1;
		op_code = op;
		op_k = r1[11:0];
		op_bit = r1[14:12];
		reg_d = r1[22:15];
		// Half the time the operands match, so equal compares occur often.
		reg_r = r1[30] ? r2[7:0] : r1[22:15];
		op_imm = r1[31] ? r2[15:8] : r1[22:15];
		io_byte = r2[23:16];
		next_two_word = r2[24];
		status_in = r3[7:0];
		pc = r3[31:10];
		pointer = r4[31:16];
		stack_pc = r4[21:0];
		seq = pc + 22'h000001;
		rel = pc + {{10{op_k[11]}}, op_k} + 22'h000001;
		skp = pc + (next_two_word ? 22'h000003 : 22'h000002);
		e = '0;
		e.pc = seq;
		e.st = status_in;
		e.pa = seq;
		case (op)
			bcu_op_relative_jump: e.pc = rel;
			bcu_op_relative_call: begin
				e.pc = rel;
				e.push = 1'b1;
			end
			bcu_op_indirect_jump: e.pc = {6'h00, pointer};
			bcu_op_indirect_call: begin
				e.pc = {6'h00, pointer};
				e.push = 1'b1;
			end
			bcu_op_subroutine_return: begin
				e.pc = stack_pc;
				e.pop = 1'b1;
			end
			bcu_op_interrupt_return: begin
				e.pc = stack_pc;
				e.pop = 1'b1;
				e.swe = 1'b1;
				e.st = status_in | 8'h80;
			end
			bcu_op_compare_skip_equal: begin
				e.grp = 2'h1;
				e.pc = (reg_d == reg_r) ? skp : seq;
			end
			bcu_op_register_compare, bcu_op_compare_with_carry,
			bcu_op_compare_immediate: begin
				e.grp = 2'h3;
				e.swe = 1'b1;
				if (op == bcu_op_compare_immediate)
					e.st = fl(status_in, reg_d, op_imm, 1'b0);
				else if (op == bcu_op_compare_with_carry)
					e.st = fl(status_in, reg_d, reg_r, status_in[0]);
				else
					e.st = fl(status_in, reg_d, reg_r, 1'b0);
			end
			bcu_op_skip_reg_bit_clear, bcu_op_skip_reg_bit_set: begin
				e.grp = 2'h1;
				if (reg_r[op_bit] == (op == bcu_op_skip_reg_bit_set))
					e.pc = skp;
			end
			bcu_op_skip_io_bit_clear, bcu_op_skip_io_bit_set: begin
				e.grp = 2'h1;
				if (io_byte[op_bit] == (op == bcu_op_skip_io_bit_set))
					e.pc = skp;
			end
			bcu_op_branch_flag_set, bcu_op_branch_flag_clear: begin
				e.grp = 2'h2;
				if (status_in[op_bit] == (op == bcu_op_branch_flag_set))
					e.pc = rel;
			end
			bcu_op_branch_carry_set, bcu_op_branch_carry_clear: begin
				e.grp = 2'h2;
				if (status_in[0] == (op == bcu_op_branch_carry_set))
					e.pc = rel;
			end
			// Idle and undefined codes only step on, with no strobe.
			default: e.grp = 2'h0;
		endcase
		notes.push_back(e);
	endtask

	// Random operations back to back, with the odd idle cycle between.
	task automatic run(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			if (xs() % 8 == 0)
				op_valid = 1'b0;
			else
				drive(bcu_op_e'(5'(xs() % 18 + 1)));
		end
		@(negedge clk);
		op_valid = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	// ======================================================================
	// Monitor: each result is matched with the oldest note
	// ======================================================================
	always @(posedge clk) begin
		bcu_note_s e;
		#1;
		if (res_valid === 1'b1 && notes.size() > 0) begin
			e = notes.pop_front();
			case (e.grp)
				2'h0: cmp_pc(pc_next, e.pc);
				2'h1: cmp_pc(pc_next, e.pc);
				2'h2: cmp_pc(pc_next, e.pc);
				default: cmp_pc(pc_next, e.pc);
			endcase
			cmp_bit(push_valid, e.push);
			if (e.push) cmp_pc(push_addr, e.pa);
			cmp_bit(pop_valid, e.pop);
			cmp_bit(status_we, e.swe);
			if (e.swe) cmp_st(status_out, e.st);
		end else begin
			// Without an accepted operation nothing may be announced.
			cmp_bit(res_valid, 1'b0);
			cmp_bit(push_valid, 1'b0);
			cmp_bit(pop_valid, 1'b0);
			cmp_bit(status_we, 1'b0);
		end
	end

	// ======================================================================
	// Main sequence
	// ======================================================================
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		srst = 1'b0;
		// Every code twice, idle and one undefined code too, then a mix.
		for (int i = 0; i <= 19; i++) begin
			@(negedge clk);
			drive(bcu_op_e'(5'(i)));
			@(negedge clk);
			drive(bcu_op_e'(5'(i)));
		end
		run(600);
		// Operations offered during a second reset must be dropped.
		srst = 1'b1;
		repeat (4) begin
			drive(bcu_op_e'(5'(xs() % 18 + 1)));
			void'(notes.pop_back());
			@(negedge clk);
		end
		srst = 1'b0;
		op_valid = 1'b0;
		@(negedge clk);
		run(600);
		cmp_bit(notes.size() == 0, 1'b1);
		report_and_stop();
	end

	// Verdict and end of run.
	task automatic report_and_stop();
		if (mismatches == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

endmodule // tb_bcu_branch_compare
